// ===== design/ppc_regs.sv
// Core port pad configuration registers behind an AXI4-Lite slave
//
// Our own choices: the address map and register access over AXI4-Lite.
`timescale 1ns/1ns
module ppc_regs (
    // Clock and reset
    input  wire logic        clk_sys,
    input  wire logic        rst,
    input  wire logic        clk_en,
    // AXI4-Lite write address and data
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [7:0]  s_axi_awaddr,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    // AXI4-Lite write response
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    output logic [1:0]       s_axi_bresp,
    // AXI4-Lite read
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    input  wire logic [7:0]  s_axi_araddr,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    // Operating mode and echo to external bus
    input  wire logic [7:0]  mode_reg,
    output logic             ext_echo,
    output logic [7:0]       ext_echo_addr,
    // Port directions, 1 = output
    input  wire logic [7:0]  dir_a,
    input  wire logic [7:0]  dir_b,
    input  wire logic [7:0]  dir_e,
    input  wire logic [7:0]  dir_k,
    // Pad controls
    output ppc_pkg::ppc_pad_t pad_a,
    output ppc_pkg::ppc_pad_t pad_b,
    output ppc_pkg::ppc_pad_t pad_e,
    output ppc_pkg::ppc_pad_t pad_k,
    // E clock
    input  wire logic        bus_clk_free,
    input  wire logic        ext_stretch_acc,
    output logic             external_bus_clock
);
    // ========================================================
    // Mode decode
    logic [2:0] op_mode_select;
    logic       in_map;
    logic       special;
    logic       single_chip;
    assign op_mode_select = mode_reg[ppc_pkg::MODE_LSB +: 3];

    ppc_mode_dec u_mode (
        .op_mode_select (op_mode_select),
        .in_map         (in_map),
        .special        (special),
        .single_chip    (single_chip)
    );

    // ========================================================
    // Registers
    logic [7:0] port_pull_enable_q;
    logic [7:0] port_drive_strength_q;
    logic       clock_stretch_sel_q;
    logic       stretch_written_q;

    // ========================================================
    // Write channel: address and data in either order
    logic       aw_held_q;
    logic [7:0] aw_addr_q;
    logic       w_held_q;
    logic [7:0] w_data_q;
    logic       w_lane0_q;
    logic       bvalid_q;
    logic [1:0] bresp_q;

    logic       wr_fire;
    logic [7:0] wr_addr;
    // Ready only while clocked, or a frozen edge would drop the item
    assign s_axi_awready = clk_en & ~aw_held_q & ~bvalid_q;
    assign s_axi_wready  = clk_en & ~w_held_q & ~bvalid_q;
    assign wr_fire = aw_held_q & w_held_q & ~bvalid_q;
    assign wr_addr = aw_addr_q;

    // Decoding shared by both channels
    function automatic logic is_mapped(input logic [7:0] a);
        is_mapped = (a == ppc_pkg::OFF_PULL) ||
                    (a == ppc_pkg::OFF_DRIVE) ||
                    (a == ppc_pkg::OFF_EBCTL) ||
                    (a == ppc_pkg::OFF_RSVD);
    endfunction : is_mapped

    logic wr_local;
    logic wr_pull;
    logic wr_drive;
    logic wr_str;
    logic str_allowed;
    assign wr_local = wr_fire & in_map & w_lane0_q;
    assign wr_pull  = wr_local & (wr_addr == ppc_pkg::OFF_PULL);
    assign wr_drive = wr_local & (wr_addr == ppc_pkg::OFF_DRIVE);
    // Special modes write anytime, others only the first time
    assign str_allowed = special | ~stretch_written_q;
    assign wr_str = wr_local & (wr_addr == ppc_pkg::OFF_EBCTL);

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            aw_held_q <= 1'b0;
            aw_addr_q <= 8'h00;
            w_held_q  <= 1'b0;
            w_data_q  <= 8'h00;
            w_lane0_q <= 1'b0;
        end else if (clk_en) begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_held_q <= 1'b1;
                aw_addr_q <= {s_axi_awaddr[7:2], 2'b00};
            end else if (wr_fire) begin
                aw_held_q <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_held_q  <= 1'b1;
                w_data_q  <= s_axi_wdata[7:0];
                w_lane0_q <= s_axi_wstrb[0];
            end else if (wr_fire) begin
                w_held_q <= 1'b0;
            end
        end
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            bvalid_q <= 1'b0;
            bresp_q  <= ppc_pkg::RESP_OKAY;
        end else if (clk_en) begin
            if (wr_fire) begin
                bvalid_q <= 1'b1;
                // Unmapped offsets answer SLVERR; unmapped mode is echoed
                bresp_q <= (is_mapped(wr_addr) || !in_map) ?
                           ppc_pkg::RESP_OKAY : ppc_pkg::RESP_SLVERR;
            end else if (s_axi_bready) begin
                bvalid_q <= 1'b0;
            end
        end
    end
    assign s_axi_bvalid = bvalid_q;
    assign s_axi_bresp  = bresp_q;

    // ========================================================
    // Configuration storage; reserved location has no storage
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            port_pull_enable_q    <= ppc_pkg::PULL_RESET;
            port_drive_strength_q <= ppc_pkg::DRIVE_RESET;
            clock_stretch_sel_q   <= ppc_pkg::STR_RESET;
            stretch_written_q     <= 1'b0;
        end else if (clk_en) begin
            if (wr_pull) begin
                port_pull_enable_q <= w_data_q & ppc_pkg::PORT_MASK;
            end
            if (wr_drive) begin
                port_drive_strength_q <= w_data_q & ppc_pkg::PORT_MASK;
            end
            if (wr_str) begin
                stretch_written_q <= 1'b1;
                if (str_allowed) begin
                    clock_stretch_sel_q <=
                        w_data_q[ppc_pkg::BIT_STRETCH];
                end
            end
        end
    end

    // ========================================================
    // Read channel
    logic        rvalid_q;
    logic [31:0] rdata_q;
    logic [1:0]  rresp_q;
    logic [7:0]  rd_addr;
    logic [7:0]  rd_val;
    logic        rd_fire;
    assign s_axi_arready = clk_en & ~rvalid_q;
    assign rd_fire = s_axi_arvalid & s_axi_arready;
    assign rd_addr = {s_axi_araddr[7:2], 2'b00};
    // Reserved location and unimplemented bits read zero
    assign rd_val =
        (rd_addr == ppc_pkg::OFF_PULL)  ? port_pull_enable_q :
        (rd_addr == ppc_pkg::OFF_DRIVE) ? port_drive_strength_q :
        (rd_addr == ppc_pkg::OFF_EBCTL) ? {7'h00, clock_stretch_sel_q} :
        8'h00;

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            rvalid_q <= 1'b0;
            rdata_q  <= 32'h0000_0000;
            rresp_q  <= ppc_pkg::RESP_OKAY;
        end else if (clk_en) begin
            if (rd_fire) begin
                rvalid_q <= 1'b1;
                rdata_q  <= in_map ? {24'h00_0000, rd_val} :
                            32'h0000_0000;
                rresp_q  <= (is_mapped(rd_addr) || !in_map) ?
                            ppc_pkg::RESP_OKAY : ppc_pkg::RESP_SLVERR;
            end else if (s_axi_rready) begin
                rvalid_q <= 1'b0;
            end
        end
    end
    assign s_axi_rvalid = rvalid_q;
    assign s_axi_rdata  = rdata_q;
    assign s_axi_rresp  = rresp_q;

    // ========================================================
    // External echo: one-cycle pulse with the access offset
    logic       echo_q;
    logic [7:0] echo_addr_q;
    logic       echo_wr;
    logic       echo_rd;
    assign echo_wr = wr_fire & ~in_map & is_mapped(wr_addr);
    assign echo_rd = rd_fire & ~in_map & is_mapped(rd_addr);
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            echo_q      <= 1'b0;
            echo_addr_q <= 8'h00;
        end else if (clk_en) begin
            echo_q <= echo_wr | echo_rd;
            if (echo_wr) begin
                echo_addr_q <= wr_addr;
            end else if (echo_rd) begin
                echo_addr_q <= rd_addr;
            end
        end
    end
    assign ext_echo      = echo_q;
    assign ext_echo_addr = echo_addr_q;

    // ========================================================
    // Per-port pad controls
    logic [3:0] pull_bits;
    logic [3:0] weak_bits;
    logic [7:0] dirs      [4];
    logic [7:0] pull_sel  [4];
    logic [7:0] rst_pull  [4];
    logic [7:0] pulls     [4];
    logic [7:0] weaks     [4];
    assign pull_bits = {port_pull_enable_q[ppc_pkg::BIT_PORT_K],
                        port_pull_enable_q[ppc_pkg::BIT_PORT_E],
                        port_pull_enable_q[ppc_pkg::BIT_PORT_B],
                        port_pull_enable_q[ppc_pkg::BIT_PORT_A]};
    assign weak_bits = {port_drive_strength_q[ppc_pkg::BIT_PORT_K],
                        port_drive_strength_q[ppc_pkg::BIT_PORT_E],
                        port_drive_strength_q[ppc_pkg::BIT_PORT_B],
                        port_drive_strength_q[ppc_pkg::BIT_PORT_A]};
    assign dirs[0] = dir_a;
    assign dirs[1] = dir_b;
    assign dirs[2] = dir_e;
    assign dirs[3] = dir_k;
    assign pull_sel[0] = 8'hFF;
    assign pull_sel[1] = 8'hFF;
    assign pull_sel[2] = ppc_pkg::PE_PULL_MASK;
    assign pull_sel[3] = 8'hFF;
    assign rst_pull[0] = 8'h00;
    assign rst_pull[1] = 8'h00;
    assign rst_pull[2] = ppc_pkg::PE_RST_MASK;
    assign rst_pull[3] = 8'h00;

    for (genvar p = 0; p < 4; p++) begin : g_port
        ppc_port_pad #(.W(8)) u_pad (
            .pull_bit   (pull_bits[p]),
            .weak_bit   (weak_bits[p]),
            .pull_sel   (pull_sel[p]),
            .rst_pull   (rst_pull[p]),
            .in_reset   (rst),
            .dir_out    (dirs[p]),
            .pull_en    (pulls[p]),
            .weak_drive (weaks[p])
        );
    end
    assign pad_a = '{pull_en: pulls[0], weak_drive: weaks[0]};
    assign pad_b = '{pull_en: pulls[1], weak_drive: weaks[1]};
    assign pad_e = '{pull_en: pulls[2], weak_drive: weaks[2]};
    assign pad_k = '{pull_en: pulls[3], weak_drive: weaks[3]};

    // ========================================================
    // E clock: free running unless stretch set outside single-chip
    logic stretch_on;
    assign stretch_on = clock_stretch_sel_q & ~single_chip;
    assign external_bus_clock = stretch_on ? ext_stretch_acc
                                           : bus_clk_free;

    // ========================================================
    // Checks
    a_pull_write: assert property (@(posedge clk_sys) disable iff (rst)
        clk_en && wr_pull |=> port_pull_enable_q ==
            ($past(w_data_q) & ppc_pkg::PORT_MASK))
        else $error("pull register write lost");
    a_unmapped_hold: assert property (@(posedge clk_sys) disable iff (rst)
        !in_map |=> $stable(port_drive_strength_q))
        else $error("drive register changed while unmapped");
    a_stretch_once: assert property (@(posedge clk_sys) disable iff (rst)
        !special && stretch_written_q |=> $stable(clock_stretch_sel_q))
        else $error("stretch bit rewritten in normal mode");
    a_free_clock: assert property (@(posedge clk_sys) disable iff (rst)
        !clock_stretch_sel_q |-> external_bus_clock == bus_clk_free)
        else $error("E clock not free running");
    a_single_chip: assert property (@(posedge clk_sys) disable iff (rst)
        single_chip |-> external_bus_clock == bus_clk_free)
        else $error("stretch active in single chip");
    a_out_no_pull: assert property (@(posedge clk_sys)
        (pad_k.pull_en & dir_k) == 8'h00)
        else $error("pull on output pin");
    a_pe_rst_pins: assert property (@(posedge clk_sys) disable iff (rst)
        (pad_e.pull_en & ppc_pkg::PE_RST_MASK) == 8'h00)
        else $error("port E reset pulls outside reset");
    a_rsvd_zero: assert property (@(posedge clk_sys) disable iff (rst)
        clk_en && rd_fire && in_map && rd_addr == ppc_pkg::OFF_RSVD
        |=> s_axi_rvalid && s_axi_rdata == 32'h0000_0000)
        else $error("reserved location not zero");
    a_frozen_state: assert property (@(posedge clk_sys) disable iff (rst)
        !clk_en |=> $stable(port_pull_enable_q) && $stable(aw_held_q))
        else $error("state moved while clock enable low");
    a_upper_zero: assert property (@(posedge clk_sys) disable iff (rst)
        (port_pull_enable_q & ~ppc_pkg::PORT_MASK) == 8'h00)
        else $error("unimplemented bit set");
    c_write: cover property (@(posedge clk_sys) disable iff (rst) wr_pull);
    c_echo: cover property (@(posedge clk_sys) disable iff (rst) ext_echo);
    c_stretch: cover property (@(posedge clk_sys) disable iff (rst)
        stretch_on && ext_stretch_acc);
endmodule : ppc_regs

// ===== design/ppc_pkg.sv
// Package: offsets, fields, modes and carriers of the core port pad config
package ppc_pkg;

    // ========================================================
    // Register byte offsets
    localparam logic [7:0] OFF_PULL   = 8'h00;
    localparam logic [7:0] OFF_DRIVE  = 8'h04;
    localparam logic [7:0] OFF_EBCTL  = 8'h08;
    localparam logic [7:0] OFF_RSVD   = 8'h0C;
    localparam logic [7:0] OFF_MODE   = 8'h10;

    // ========================================================
    // Field positions
    localparam int BIT_PORT_K   = 7;
    localparam int BIT_PORT_E   = 4;
    localparam int BIT_PORT_B   = 1;
    localparam int BIT_PORT_A   = 0;
    localparam int BIT_STRETCH  = 0;
    localparam int MODE_LSB     = 5;

    // Implemented bit masks of the pull, drive and stretch registers
    localparam logic [7:0] PORT_MASK   = 8'h93;
    localparam logic [7:0] STRETCH_MASK = 8'h01;
    // Port E pins that follow the pull enable bit
    localparam logic [7:0] PE_PULL_MASK = 8'h9F;
    // Port E pins pulled only during reset
    localparam logic [7:0] PE_RST_MASK  = 8'h60;

    // ========================================================
    // Reset values
    localparam logic [7:0] PULL_RESET   = 8'h00;
    localparam logic [7:0] DRIVE_RESET  = 8'h00;
    localparam logic       STR_RESET    = 1'b0;

    // ========================================================
    // AXI responses
    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // ========================================================
    // Operating modes, three select bits
    typedef enum logic [2:0] {
        MODE_SPEC_SC   = 3'h0,
        MODE_EMU_NAR   = 3'h1,
        MODE_SPEC_TEST = 3'h2,
        MODE_EMU_WIDE  = 3'h3,
        MODE_NORM_SC   = 3'h4,
        MODE_NORM_NAR  = 3'h5,
        MODE_PERIPH    = 3'h6,
        MODE_NORM_WIDE = 3'h7
    } ppc_mode_t;

    // Pad controls of one port
    typedef struct packed {
        logic [7:0] pull_en;
        logic [7:0] weak_drive;
    } ppc_pad_t;

endpackage : ppc_pkg

// ===== design/ppc_mode_dec.sv
// Mode decoder: map presence, special and single-chip flags
`timescale 1ns/1ns
module ppc_mode_dec (
    // Mode select
    input  wire logic [2:0] op_mode_select,
    // Decoded flags
    output logic            in_map,
    output logic            special,
    output logic            single_chip
);
    // ========================================================
    // Decode
    ppc_pkg::ppc_mode_t m;
    assign m = ppc_pkg::ppc_mode_t'(op_mode_select);
    // Only single-chip and special test keep the registers mapped
    assign in_map = (m == ppc_pkg::MODE_SPEC_SC) ||
                    (m == ppc_pkg::MODE_NORM_SC) ||
                    (m == ppc_pkg::MODE_SPEC_TEST);
    assign special = ~op_mode_select[2] & ~op_mode_select[0];
    assign single_chip = (m == ppc_pkg::MODE_SPEC_SC) ||
                         (m == ppc_pkg::MODE_NORM_SC);
endmodule : ppc_mode_dec

// ===== design/ppc_port_pad.sv
// One port: pull and drive controls gated by pin direction
`timescale 1ns/1ns
module ppc_port_pad #(
    parameter int W = 8
) (
    // Controls
    input  wire logic         pull_bit,
    input  wire logic         weak_bit,
    input  wire logic [W-1:0] pull_sel,
    input  wire logic [W-1:0] rst_pull,
    input  wire logic         in_reset,
    input  wire logic [W-1:0] dir_out,
    // Pad controls
    output logic [W-1:0]      pull_en,
    output logic [W-1:0]      weak_drive
);
    // ========================================================
    // Gating
    if (W < 1) begin : g_bad_width
        $error("width must be positive");
    end
    // Outputs never pull; reset-only pins ignore the enable bit
    assign pull_en = ~dir_out & ((pull_sel & {W{pull_bit}}) |
                                 (rst_pull & {W{in_reset}}));
    // Drive strength applies whatever function owns the pin
    assign weak_drive = dir_out & {W{weak_bit}};
endmodule : ppc_port_pad

// ===== sim/ppc_regs_tb_top.sv
// Testbench of the core port pad configuration registers
`timescale 1ns/1ns
module ppc_regs_tb_top;
    // ========================================================
    // Design signals
    logic              clk_sys = 1'b0;
    logic              rst = 1'b1;
    logic              clk_en = 1'b1;
    logic              s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0;
    logic              s_axi_bready = 1'b0, s_axi_arvalid = 1'b0;
    logic              s_axi_rready = 1'b0;
    logic [7:0]        s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
    logic [31:0]       s_axi_wdata = 32'h0000_0000;
    logic [3:0]        s_axi_wstrb = 4'h0;
    logic              s_axi_awready, s_axi_wready, s_axi_bvalid;
    logic              s_axi_arready, s_axi_rvalid;
    logic [1:0]        s_axi_bresp, s_axi_rresp;
    logic [31:0]       s_axi_rdata;
    logic [7:0]        mode_reg = 8'h00;
    logic              ext_echo;
    logic [7:0]        ext_echo_addr;
    logic              bus_clk_free = 1'b0, ext_stretch_acc = 1'b0;
    logic              external_bus_clock;
    ppc_pkg::ppc_pad_t pads [4];
    // Port order a, b, e, k; mixed directions so pulls show gating
    logic [7:0]        dirs [4] = '{8'h0F, 8'h33, 8'h41, 8'hC3};
    logic [7:0]        pmask [4] = '{8'hFF, 8'hFF, ppc_pkg::PE_PULL_MASK,
                                     8'hFF};
    int                pos [4] = '{0, 1, 4, 7};
    int                mismatches = 0;
    int                num_checks = 0;
    int                echo_cnt = 0;
    logic [7:0]        echo_addr_seen = 8'h00;

    ppc_regs DUT (.clk_sys, .rst, .clk_en, .s_axi_awvalid, .s_axi_awready,
        .s_axi_awaddr, .s_axi_wvalid, .s_axi_wready, .s_axi_wdata,
        .s_axi_wstrb, .s_axi_bvalid, .s_axi_bready, .s_axi_bresp,
        .s_axi_arvalid, .s_axi_arready, .s_axi_araddr, .s_axi_rvalid,
        .s_axi_rready, .s_axi_rdata, .s_axi_rresp, .mode_reg, .ext_echo,
        .ext_echo_addr, .dir_a(dirs[0]), .dir_b(dirs[1]), .dir_e(dirs[2]),
        .dir_k(dirs[3]), .pad_a(pads[0]), .pad_b(pads[1]), .pad_e(pads[2]),
        .pad_k(pads[3]), .bus_clk_free, .ext_stretch_acc,
        .external_bus_clock);

    always #10 clk_sys = ~clk_sys;

    // Echo pulse lasts one cycle, so it is counted away from the edge
    always @(negedge clk_sys) begin
        if (ext_echo === 1'b1) begin
            echo_cnt++;
            echo_addr_seen = ext_echo_addr;
        end
    end

    // ========================================================
    // Report and compare
    task automatic test_done();
        if (mismatches == 0 && num_checks > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask : test_done

    task automatic chk(input string what, input logic [31:0] exp,
                       input logic [31:0] got);
        num_checks++;
        if (got !== exp) begin
            mismatches++;
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
        end
    endtask : chk

    task automatic chk_resp(input string what, input logic [1:0] exp,
                            input logic [1:0] got);
        num_checks++;
        if (got !== exp) begin
            mismatches++;
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
        end
    endtask : chk_resp

    // ========================================================
    // AXI4-Lite master: readiness sampled mid-cycle, released after edge
    task automatic axi_xfer(input logic wr, input logic [7:0] addr,
                            input logic [7:0] data, output logic [31:0] rd,
                            output logic [1:0] resp);
        logic aw_t, w_t, ar_t, done;
        int   n;
        done = 1'b0;
        @(posedge clk_sys);
        if (wr) begin
            s_axi_awvalid <= 1'b1;
            s_axi_awaddr  <= addr;
            s_axi_wvalid  <= 1'b1;
            s_axi_wdata   <= {24'h00_0000, data};
            s_axi_wstrb   <= 4'h1;
            s_axi_bready  <= 1'b1;
        end else begin
            s_axi_arvalid <= 1'b1;
            s_axi_araddr  <= addr;
            s_axi_rready  <= 1'b1;
        end
        for (n = 0; n < 40 && !done; n++) begin
            @(negedge clk_sys);
            aw_t = s_axi_awvalid && s_axi_awready === 1'b1;
            w_t  = s_axi_wvalid && s_axi_wready === 1'b1;
            ar_t = s_axi_arvalid && s_axi_arready === 1'b1;
            done = wr ? s_axi_bvalid === 1'b1 : s_axi_rvalid === 1'b1;
            rd   = s_axi_rdata;
            resp = wr ? s_axi_bresp : s_axi_rresp;
            @(posedge clk_sys);
            if (aw_t) s_axi_awvalid <= 1'b0;
            if (w_t) s_axi_wvalid <= 1'b0;
            if (ar_t) s_axi_arvalid <= 1'b0;
            if (done) begin
                s_axi_bready <= 1'b0;
                s_axi_rready <= 1'b0;
            end
        end
        if (!done) begin
            mismatches++;
            test_done();
        end
    endtask : axi_xfer

    task automatic wr(input logic [7:0] addr, input logic [7:0] data,
                      input logic [1:0] exp_resp);
        logic [31:0] d;
        logic [1:0]  r;
        axi_xfer(1'b1, addr, data, d, r);
        chk_resp("bresp", exp_resp, r);
    endtask : wr

    task automatic rd_chk(input logic [7:0] addr, input logic [7:0] exp,
                          input logic [1:0] exp_resp);
        logic [31:0] d;
        logic [1:0]  r;
        axi_xfer(1'b0, addr, 8'h00, d, r);
        chk_resp("rresp", exp_resp, r);
        chk("rdata", {24'h00_0000, exp}, d);
    endtask : rd_chk

    // Only port sel has pull and weak drive; weak drive seen on outputs
    task automatic chk_pads(input int sel);
        for (int p = 0; p < 4; p++) begin
            chk("pull_en", p == sel ? pmask[p] & ~dirs[p] : 8'h00,
                pads[p].pull_en);
            chk("weak_drive", p == sel ? dirs[p] : 8'h00,
                pads[p].weak_drive);
        end
    endtask : chk_pads

    task automatic chk_clk(input logic stretched);
        for (int i = 0; i < 4; i++) begin
            @(posedge clk_sys);
            bus_clk_free    <= i[0];
            ext_stretch_acc <= i[1];
            @(negedge clk_sys);
            chk("e clock", stretched ? i[1] : i[0], external_bus_clock);
        end
        @(posedge clk_sys);
    endtask : chk_clk

    // ========================================================
    // Main sequence
    initial begin
        int ec;
        repeat (6) @(posedge clk_sys);
        chk("reset pull e", ppc_pkg::PE_RST_MASK & ~dirs[2],
            pads[2].pull_en);
        rst <= 1'b0;
        @(posedge clk_sys);
        @(negedge clk_sys);
        chk("run pull e", 8'h00, pads[2].pull_en);
        rd_chk(ppc_pkg::OFF_PULL, 8'h00, ppc_pkg::RESP_OKAY);
        rd_chk(ppc_pkg::OFF_DRIVE, 8'h00, ppc_pkg::RESP_OKAY);
        rd_chk(ppc_pkg::OFF_EBCTL, 8'h00, ppc_pkg::RESP_OKAY);
        wr(ppc_pkg::OFF_PULL, 8'hFF, ppc_pkg::RESP_OKAY);
        rd_chk(ppc_pkg::OFF_PULL, ppc_pkg::PORT_MASK,
               ppc_pkg::RESP_OKAY);
        wr(ppc_pkg::OFF_DRIVE, 8'hFF, ppc_pkg::RESP_OKAY);
        rd_chk(ppc_pkg::OFF_DRIVE, ppc_pkg::PORT_MASK,
               ppc_pkg::RESP_OKAY);
        wr(ppc_pkg::OFF_RSVD, 8'hFF, ppc_pkg::RESP_OKAY);
        rd_chk(ppc_pkg::OFF_RSVD, 8'h00, ppc_pkg::RESP_OKAY);
        for (int i = 0; i < 4; i++) begin
            wr(ppc_pkg::OFF_PULL, 8'h01 << pos[i],
               ppc_pkg::RESP_OKAY);
            wr(ppc_pkg::OFF_DRIVE, 8'h01 << pos[i],
               ppc_pkg::RESP_OKAY);
            chk_pads(i);
        end
        wr(8'h20, 8'h01, ppc_pkg::RESP_SLVERR);
        rd_chk(8'h20, 8'h00, ppc_pkg::RESP_SLVERR);
        // Special single chip: stretch writable, but E clock stays free
        wr(ppc_pkg::OFF_EBCTL, 8'h01, ppc_pkg::RESP_OKAY);
        rd_chk(ppc_pkg::OFF_EBCTL, 8'h01, ppc_pkg::RESP_OKAY);
        chk_clk(1'b0);
        mode_reg <= {ppc_pkg::MODE_SPEC_TEST, 5'h00};
        chk_clk(1'b1);
        wr(ppc_pkg::OFF_EBCTL, 8'h00, ppc_pkg::RESP_OKAY);
        rd_chk(ppc_pkg::OFF_EBCTL, 8'h00, ppc_pkg::RESP_OKAY);
        chk_clk(1'b0);
        // Expanded and peripheral modes: accesses go outside
        mode_reg <= {ppc_pkg::MODE_NORM_NAR, 5'h00};
        ec = echo_cnt;
        rd_chk(ppc_pkg::OFF_PULL, 8'h00, ppc_pkg::RESP_OKAY);
        wr(ppc_pkg::OFF_DRIVE, 8'h00, ppc_pkg::RESP_OKAY);
        repeat (2) @(posedge clk_sys);
        chk("echo count", ec + 2, echo_cnt);
        chk("echo addr", ppc_pkg::OFF_DRIVE, echo_addr_seen);
        mode_reg <= {ppc_pkg::MODE_PERIPH, 5'h00};
        wr(ppc_pkg::OFF_PULL, 8'h00, ppc_pkg::RESP_OKAY);
        repeat (2) @(posedge clk_sys);
        chk("echo addr", ppc_pkg::OFF_PULL, echo_addr_seen);
        mode_reg <= {ppc_pkg::MODE_SPEC_SC, 5'h00};
        rd_chk(ppc_pkg::OFF_DRIVE, 8'h80, ppc_pkg::RESP_OKAY);
        rd_chk(ppc_pkg::OFF_PULL, 8'h80, ppc_pkg::RESP_OKAY);
        // Normal single chip from a fresh reset: stretch takes one write
        rst      <= 1'b1;
        mode_reg <= {ppc_pkg::MODE_NORM_SC, 5'h00};
        repeat (2) @(posedge clk_sys);
        rst <= 1'b0;
        @(posedge clk_sys);
        wr(ppc_pkg::OFF_EBCTL, 8'h01, ppc_pkg::RESP_OKAY);
        wr(ppc_pkg::OFF_EBCTL, 8'h00, ppc_pkg::RESP_OKAY);
        rd_chk(ppc_pkg::OFF_EBCTL, 8'h01, ppc_pkg::RESP_OKAY);
        chk_clk(1'b0);
        // Clock enable low: the write must wait until it rises again
        clk_en <= 1'b0;
        fork
            wr(ppc_pkg::OFF_PULL, 8'h93, ppc_pkg::RESP_OKAY);
            begin
                repeat (3) @(posedge clk_sys);
                clk_en <= 1'b1;
            end
        join
        rd_chk(ppc_pkg::OFF_PULL, 8'h93, ppc_pkg::RESP_OKAY);
        test_done();
    end
endmodule : ppc_regs_tb_top
